// file: rtl/card_irq_pkg.sv
// Constants shared by the smart card interrupt flag logic.
// Assumes byte addressing on the register bus, one 32-bit word per register.
package card_irq_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] SELECT_IDX  = 16'hfe00;
  localparam logic [15:0] STATUS_IDX  = 16'hfe01;
  localparam logic [15:0] ENABLE_IDX  = 16'hfe02;
  localparam logic [15:0] MODE_IDX    = 16'hfe10;
  localparam logic [15:0] LIMIT_IDX   = 16'hfe11;
  localparam int          ADDR_W      = 18;
  localparam int          WORD_LSB    = 2;

  // Reset values
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [7:0]  ENABLE_RST  = 8'h00;
  localparam logic [1:0]  SELECT_RST  = 2'h0;
  localparam logic [4:0]  MODE_RST    = 5'h00;
  localparam logic [7:0]  LIMIT_RST   = 8'h00;

  // Status and enable bit positions
  localparam int WAIT_TIMEOUT_BIT = 7;
  localparam int CARD_EVENT_BIT   = 6;
  localparam int SUPPLY_TIMER_BIT = 5;
  localparam int RX_AVAILABLE_BIT = 4;
  localparam int TX_EVENT_BIT     = 3;
  localparam int BYTE_SENT_BIT    = 2;
  localparam int TX_ERROR_BIT     = 1;
  localparam int RX_ERROR_BIT     = 0;

  // Flags cleared by reading the status register
  localparam logic [7:0] READ_CLEAR_MASK = 8'he4;
  // Flags cleared by reading the transmit control register
  localparam logic [7:0] TX_READ_CLEAR_MASK = 8'h0a;
  // Flags cleared by reading the receive control register
  localparam logic [7:0] RX_READ_CLEAR_MASK = 8'h01;

  // Select register layout
  localparam int SEL_LSB    = 2;
  localparam int BYPASS_BIT = 1;
  localparam logic [1:0] SEL_NONE     = 2'h0;
  localparam logic [1:0] SEL_EXTERNAL = 2'h1;

  // Mode register layout
  localparam int SYNC_MODE_BIT   = 0;
  localparam int CLOCK_STOP_BIT  = 1;
  localparam int BLOCK_PROTO_BIT = 2;
  localparam int BREAK_DET_BIT   = 3;
  localparam int POWER_DOWN_BIT  = 4;

endpackage : card_irq_pkg

// file: rtl/card_irq_flags.sv
// Smart card interrupt status and enable registers with one interrupt line.
// Assumes all event inputs are synchronous to clock_i; strobes are one cycle.
//
// Behaviour
// - Timeout flag, bit 7, sets on ATR or wait timeout in async operation.
// - Sync mode: bit 7 sets when receive-length counter reaches its loaded maximum.
// - Sync clock-stop mode: bit 7 is the receive-length terminal-count interrupt.
// - Card-event flag, bit 6, sets on card insert, removal or interface fault.
// - Card-event logic works with logic clock gated off or power-down set.
// - Status read clears bits 7, 6, 5 and 2.
// - Supply-timer flag, bit 5, sets when the supply stable timer expires.
// - Bit 4 follows non-empty receive FIFO; a status read never clears it.
// - Bypass mode: bit 4 rises on each falling edge of card I/O.
// - Tx-event flag, bit 3, sets on tx empty or full; transmit control read clears.
// - Byte-sent flag, bit 2, sets per byte sent, and after CRC/LRC in block mode.
// - Character mode with break detection: break at byte end suppresses byte-sent.
// - Tx-error flag, bit 1, sets on break or underrun; transmit control read clears.
// - Rx-error flag, bit 0, on overrun or parity error; receive control read clears.
// - Enable bit 1 passes its flag to the interrupt; 0 blocks, flag still sets.
// - Enable bits share status positions; bit 7 covers timeout and length limit.
// - Enable register resets to zero.
// - Flags follow the card interface chosen by the select field.
// - Status register at index 0xFE01 (byte address 0x3F804), reset to zero.
`timescale 1ns/1ps
`default_nettype none

module card_irq_flags #(
  parameter int COUNT_W = 8
) (
  input  wire logic                             clock_i,
  input  wire logic                             resetn_i,
  // Avalon-MM slave
  input  wire logic [card_irq_pkg::ADDR_W-1:0]  address_i,
  input  wire logic                             read_i,
  input  wire logic                             write_i,
  input  wire logic [31:0]                      writedata_i,
  input  wire logic [3:0]                       byteenable_i,
  output logic      [31:0]                      readdata_o,
  output logic                                  waitrequest_o,
  // Card side events
  input  wire logic                             logic_clk_en_i,
  input  wire logic                             card_detect_ext_i,
  input  wire logic                             card_detect_int_i,
  input  wire logic                             iface_fault_i,
  input  wire logic                             atr_timeout_i,
  input  wire logic                             wait_timeout_i,
  input  wire logic                             length_step_i,
  input  wire logic                             supply_timer_done_i,
  input  wire logic                             rx_fifo_not_empty_i,
  input  wire logic                             card_io_i,
  input  wire logic                             tx_empty_i,
  input  wire logic                             tx_full_i,
  input  wire logic                             byte_sent_i,
  input  wire logic                             check_byte_sent_i,
  input  wire logic                             break_at_end_i,
  input  wire logic                             break_detected_i,
  input  wire logic                             tx_underrun_i,
  input  wire logic                             rx_overrun_i,
  input  wire logic                             rx_parity_err_i,
  input  wire logic                             tx_ctl_read_i,
  input  wire logic                             rx_ctl_read_i,
  // Interrupt to the processor
  output logic                                  irq_o
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic               wait_n;
    logic [7:0]         rdata;
    logic [7:0]         status;
    logic [7:0]         enable;
    logic [1:0]         select;
    logic               bypass;
    logic [4:0]         mode;
    logic [COUNT_W-1:0] limit;
    logic [COUNT_W-1:0] count;
    logic               step_prev;
    logic               io_prev;
    logic               det_ext_prev;
    logic               det_int_prev;
    logic               tx_ind_prev;
    logic               tx_err_prev;
    logic               irq;
  } state_type;

  state_type state_reg;
  state_type state_next;

  function automatic logic hits(input logic [card_irq_pkg::ADDR_W-1:0] addr,
                                input logic [15:0] idx);
    hits = addr[card_irq_pkg::ADDR_W-1:card_irq_pkg::WORD_LSB] == idx;
  endfunction

  function automatic logic fall(input logic prev, input logic cur);
    fall = prev & ~cur;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic               accept;
  logic               do_read;
  logic               do_write;
  logic               sync_mode;
  logic               block_mode;
  logic               uart_live;
  logic               det_edge;
  logic               limit_hit;
  logic [COUNT_W-1:0] count_inc;
  logic [7:0]         event_set;
  logic [7:0]         clear_mask;
  logic               tx_ind;
  logic               tx_err;
  logic               suppress_sent;

  always_comb begin
    state_next = state_reg;

    // One accept per request; the cycle after acks is a gap
    accept   = (read_i | write_i) & state_reg.wait_n;
    do_read  = accept & read_i;
    do_write = accept & write_i & byteenable_i[0];

    sync_mode  = state_reg.mode[card_irq_pkg::SYNC_MODE_BIT];
    block_mode = state_reg.mode[card_irq_pkg::BLOCK_PROTO_BIT];

    // UART sources only count for a selected, clocked, powered interface
    uart_live = (state_reg.select != card_irq_pkg::SEL_NONE) & logic_clk_en_i
              & ~state_reg.mode[card_irq_pkg::POWER_DOWN_BIT];

    // Card detect of the selected slot; never gated by clock or power-down
    if (state_reg.select == card_irq_pkg::SEL_NONE) begin
      det_edge = 1'b0;
    end else if (state_reg.select == card_irq_pkg::SEL_EXTERNAL) begin
      det_edge = state_reg.det_ext_prev ^ card_detect_ext_i;
    end else begin
      det_edge = state_reg.det_int_prev ^ card_detect_int_i;
    end

    // Receive-length counter steps on falling edges of clock or ETU
    count_inc = state_reg.count + COUNT_W'(1);
    limit_hit = 1'b0;
    if (uart_live & sync_mode & fall(state_reg.step_prev, length_step_i)
        & (state_reg.count != state_reg.limit)) begin
      state_next.count = count_inc;
      limit_hit        = count_inc == state_reg.limit;
    end

    tx_ind = tx_empty_i | tx_full_i;
    tx_err = break_detected_i | tx_underrun_i;
    suppress_sent = ~block_mode & state_reg.mode[card_irq_pkg::BREAK_DET_BIT]
                  & break_at_end_i;

    event_set = 8'h00;
    event_set[card_irq_pkg::WAIT_TIMEOUT_BIT] = uart_live
      & (sync_mode ? limit_hit : (atr_timeout_i | wait_timeout_i));
    event_set[card_irq_pkg::CARD_EVENT_BIT] = det_edge | iface_fault_i;
    event_set[card_irq_pkg::SUPPLY_TIMER_BIT] = uart_live & supply_timer_done_i;
    event_set[card_irq_pkg::TX_EVENT_BIT] = uart_live & tx_ind
      & ~state_reg.tx_ind_prev;
    event_set[card_irq_pkg::BYTE_SENT_BIT] = uart_live
      & ((byte_sent_i & ~suppress_sent) | (block_mode & check_byte_sent_i));
    event_set[card_irq_pkg::TX_ERROR_BIT] = uart_live & tx_err
      & ~state_reg.tx_err_prev;
    event_set[card_irq_pkg::RX_ERROR_BIT] = uart_live
      & (rx_overrun_i | rx_parity_err_i);

    clear_mask = 8'h00;
    if (do_read & hits(address_i, card_irq_pkg::STATUS_IDX)) begin
      clear_mask = clear_mask | card_irq_pkg::READ_CLEAR_MASK;
    end
    if (tx_ctl_read_i) begin
      clear_mask = clear_mask | card_irq_pkg::TX_READ_CLEAR_MASK;
    end
    if (rx_ctl_read_i) begin
      clear_mask = clear_mask | card_irq_pkg::RX_READ_CLEAR_MASK;
    end

    // Set beats clear so an event in the read cycle survives
    state_next.status = (state_reg.status & ~clear_mask) | event_set;

    // Data-available is a level, untouched by any register read
    if (state_reg.bypass) begin
      if (uart_live & fall(state_reg.io_prev, card_io_i)) begin
        state_next.status[card_irq_pkg::RX_AVAILABLE_BIT] = 1'b1;
      end else if (card_io_i) begin
        state_next.status[card_irq_pkg::RX_AVAILABLE_BIT] = 1'b0;
      end
    end else begin
      state_next.status[card_irq_pkg::RX_AVAILABLE_BIT] =
        uart_live & rx_fifo_not_empty_i;
    end

    // Edge history
    state_next.step_prev    = length_step_i;
    state_next.io_prev      = card_io_i;
    state_next.det_ext_prev = card_detect_ext_i;
    state_next.det_int_prev = card_detect_int_i;
    state_next.tx_ind_prev  = tx_ind;
    state_next.tx_err_prev  = tx_err;

    // Register writes
    if (do_write) begin
      if (hits(address_i, card_irq_pkg::SELECT_IDX)) begin
        state_next.select = writedata_i[card_irq_pkg::SEL_LSB +: 2];
        state_next.bypass = writedata_i[card_irq_pkg::BYPASS_BIT];
      end
      if (hits(address_i, card_irq_pkg::ENABLE_IDX)) begin
        state_next.enable = writedata_i[7:0];
      end
      if (hits(address_i, card_irq_pkg::MODE_IDX)) begin
        state_next.mode = writedata_i[4:0];
      end
      if (hits(address_i, card_irq_pkg::LIMIT_IDX)) begin
        // Loading a new maximum restarts the count
        state_next.limit = writedata_i[COUNT_W-1:0];
        state_next.count = '0;
      end
    end

    // Read data returns the value before any read side effect
    state_next.rdata = 8'h00;
    if (do_read) begin
      if (hits(address_i, card_irq_pkg::SELECT_IDX)) begin
        state_next.rdata = {4'h0, state_reg.select, state_reg.bypass, 1'b0};
      end else if (hits(address_i, card_irq_pkg::STATUS_IDX)) begin
        state_next.rdata = state_reg.status;
      end else if (hits(address_i, card_irq_pkg::ENABLE_IDX)) begin
        state_next.rdata = state_reg.enable;
      end else if (hits(address_i, card_irq_pkg::MODE_IDX)) begin
        state_next.rdata = {3'h0, state_reg.mode};
      end else if (hits(address_i, card_irq_pkg::LIMIT_IDX)) begin
        state_next.rdata = 8'(state_reg.count);
      end
    end
    state_next.wait_n = ~accept;

    // Computed from next values so the line tracks the flags cycle for cycle
    state_next.irq = |(state_next.status & state_next.enable);
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg.wait_n       <= 1'b1;
      state_reg.rdata        <= 8'h00;
      state_reg.status       <= card_irq_pkg::STATUS_RST;
      state_reg.enable       <= card_irq_pkg::ENABLE_RST;
      state_reg.select       <= card_irq_pkg::SELECT_RST;
      state_reg.bypass       <= 1'b0;
      state_reg.mode         <= card_irq_pkg::MODE_RST;
      state_reg.limit        <= COUNT_W'(card_irq_pkg::LIMIT_RST);
      state_reg.count        <= '0;
      state_reg.step_prev    <= 1'b0;
      state_reg.io_prev      <= 1'b1;
      state_reg.det_ext_prev <= 1'b0;
      state_reg.det_int_prev <= 1'b0;
      state_reg.tx_ind_prev  <= 1'b0;
      state_reg.tx_err_prev  <= 1'b0;
      state_reg.irq          <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign readdata_o    = {24'h000000, state_reg.rdata};
  assign waitrequest_o = state_reg.wait_n;
  assign irq_o         = state_reg.irq;

endmodule : card_irq_flags

`default_nettype wire

// file: verif/card_irq_flags_assertions.sv
// Checker for the card interrupt flags: bus handshake, enable gating, read-back.
// Bound to card_irq_flags; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module card_irq_flags_assertions (
  input wire logic                            clock_i,
  input wire logic                            resetn_i,
  input wire logic [card_irq_pkg::ADDR_W-1:0] address_i,
  input wire logic                            read_i,
  input wire logic                            write_i,
  input wire logic [31:0]                     writedata_i,
  input wire logic [3:0]                      byteenable_i,
  input wire logic [31:0]                     readdata_o,
  input wire logic                            waitrequest_o,
  input wire logic                            iface_fault_i,
  input wire logic                            irq_o
);
  logic [7:0]  en_sh_reg;
  logic        st_rd_reg;
  logic        en_rd_reg;
  wire         take = (read_i || write_i) && waitrequest_o;
  wire  [15:0] idx  = address_i[17:2];
  // Shadow of the enable register, rebuilt from bus writes
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_sh_reg <= 8'h00;
      st_rd_reg <= 1'b0;
      en_rd_reg <= 1'b0;
    end else begin
      if (take && write_i && byteenable_i[0] && idx == card_irq_pkg::ENABLE_IDX) begin
        en_sh_reg <= writedata_i[7:0];
      end
      st_rd_reg <= take && read_i && idx == card_irq_pkg::STATUS_IDX;
      en_rd_reg <= take && read_i && idx == card_irq_pkg::ENABLE_IDX;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  property p_reset_quiet; $rose(resetn_i) |-> !irq_o && waitrequest_o; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
  property p_gated; en_sh_reg == 8'h00 && $past(en_sh_reg) == 8'h00 |-> !irq_o; endproperty
  a_gated: assert property (p_gated) else $error("irq with all enables off");
  property p_irq_or; st_rd_reg && $stable(en_sh_reg)
    |-> $past(irq_o) == |(readdata_o[7:0] & en_sh_reg); endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not status and enable");
  property p_answer; take |=> !waitrequest_o; endproperty
  a_answer: assert property (p_answer) else $error("no answer next cycle");
  property p_one_ack; !waitrequest_o |=> waitrequest_o; endproperty
  a_one_ack: assert property (p_one_ack) else $error("ack held too long");
  property p_idle_zero; waitrequest_o |-> readdata_o == 32'h00000000; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data while idle");
  property p_en_back; en_rd_reg |-> readdata_o == {24'h000000, en_sh_reg}; endproperty
  a_en_back: assert property (p_en_back) else $error("enable read back wrong");
  property p_card_evt; iface_fault_i && en_sh_reg[6] && $past(en_sh_reg[6]) |=> irq_o;
  endproperty
  a_card_evt: assert property (p_card_evt) else $error("card event lost");
endmodule // card_irq_flags_assertions
bind card_irq_flags card_irq_flags_assertions card_irq_flags_assertions_inst (.clock_i,
  .resetn_i, .address_i, .read_i, .write_i, .writedata_i, .byteenable_i, .readdata_o,
  .waitrequest_o, .iface_fault_i, .irq_o);
`default_nettype wire

// file: verif/fw_master.sv
// Firmware side model: Avalon-MM master doing register reads and writes.
// Assumes a slave that answers by dropping waitrequest.
`timescale 1ns/1ps
`default_nettype none
module fw_master (
  input  wire logic                            clock_i,
  input  wire logic [31:0]                     readdata_i,
  input  wire logic                            waitrequest_i,
  output logic      [card_irq_pkg::ADDR_W-1:0] address_o,
  output logic                                 read_o,
  output logic                                 write_o,
  output logic      [31:0]                     writedata_o
);
  initial begin
    address_o = '0;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = '0;
  end
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clock_i);
    address_o   <= {i, 2'b00};
    read_o      <= !w;
    write_o     <= w;
    writedata_o <= {24'h000000, d};
    @(posedge clock_i);
    while (waitrequest_i !== 1'b0) @(posedge clock_i);
    q = readdata_i[7:0];
    read_o      <= 1'b0;
    write_o     <= 1'b0;
    // Stale values must not look valid after release
    address_o   <= ~address_o;
    writedata_o <= ~writedata_o;
  endtask
endmodule // fw_master
`default_nettype wire

// file: verif/tb_card_irq_flags.sv
// Self-checking bench for the card interrupt flags.
// Drives event inputs directly; registers go through fw_master.
`timescale 1ns/1ps
`default_nettype none
module tb_card_irq_flags;
  localparam logic [15:0] ST = card_irq_pkg::STATUS_IDX;
  localparam logic [15:0] EN = card_irq_pkg::ENABLE_IDX;
  localparam logic [15:0] SL = card_irq_pkg::SELECT_IDX;
  localparam logic [15:0] MD = card_irq_pkg::MODE_IDX;
  localparam logic [15:0] LM = card_irq_pkg::LIMIT_IDX;
  logic clock_i = 1'b0, resetn_i = 1'b0, read_i, write_i, waitrequest_o, irq_o;
  logic [card_irq_pkg::ADDR_W-1:0] address_i;
  logic [31:0] writedata_i, readdata_o;
  logic [3:0]  byteenable_i = 4'h1;
  logic logic_clk_en_i, card_detect_ext_i, card_detect_int_i, rx_fifo_not_empty_i, card_io_i,
    tx_empty_i, tx_full_i, break_at_end_i, break_detected_i, tx_underrun_i;
  // One-cycle event inputs, one bit each, raised one at a time by pulse
  localparam logic [10:0] TMO = 11'h001, SUP = 11'h002, SENT = 11'h004, FLT = 11'h008,
    ATR = 11'h010, PAR = 11'h020, OVR = 11'h040, TXRD = 11'h080, RXRD = 11'h100,
    CHK = 11'h200, STEP = 11'h400;
  logic [10:0] strobe = 11'h000;
  logic length_step_i, check_byte_sent_i, rx_ctl_read_i, tx_ctl_read_i, rx_overrun_i,
    rx_parity_err_i, atr_timeout_i, iface_fault_i, byte_sent_i, supply_timer_done_i,
    wait_timeout_i;
  assign {length_step_i, check_byte_sent_i, rx_ctl_read_i, tx_ctl_read_i, rx_overrun_i,
    rx_parity_err_i, atr_timeout_i, iface_fault_i, byte_sent_i, supply_timer_done_i,
    wait_timeout_i} = strobe;
  int num_errors = 0, num_checks = 0, cycles = 0;
  logic [7:0] q;
  card_irq_flags card_irq_flags_inst (.*);
  fw_master fw_master_inst (.clock_i, .readdata_i(readdata_o), .waitrequest_i(waitrequest_o),
    .address_o(address_i), .read_o(read_i), .write_o(write_i), .writedata_o(writedata_i));
  initial begin
    {logic_clk_en_i, card_detect_ext_i, card_detect_int_i, rx_fifo_not_empty_i, card_io_i,
     tx_empty_i, tx_full_i, break_at_end_i, break_detected_i, tx_underrun_i} = 10'h000;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic stop_test;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      stop_test;
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    fw_master_inst.xfer(1'b1, i, d, q);
  endtask
  task automatic rchk(input logic [15:0] i, input logic [7:0] e);
    fw_master_inst.xfer(1'b0, i, 8'h00, q);
    check(q, e);
  endtask
  task automatic pulse(input logic [10:0] m);
    @(posedge clock_i);
    strobe <= m;
    @(posedge clock_i);
    strobe <= 11'h000;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(ST, 8'h00);
    rchk(EN, 8'h00);
    wr(16'h0100, 8'h5a);
    rchk(16'h0100, 8'h00);
    wr(EN, 8'h5a);
    rchk(EN, 8'h5a);
    byteenable_i <= 4'h0;
    wr(EN, 8'hff);
    byteenable_i <= 4'h1;
    rchk(EN, 8'h5a);
    wr(EN, 8'h00);
  endtask
  task automatic t_events;
    wr(SL, 8'h04);
    logic_clk_en_i <= 1'b1;
    pulse(TMO);
    pulse(SUP);
    pulse(SENT);
    pulse(FLT);
    rchk(ST, 8'he4);
    rchk(ST, 8'h00);
    pulse(ATR);
    rchk(ST, 8'h80);
    rx_fifo_not_empty_i <= 1'b1;
    rchk(ST, 8'h10);
    rchk(ST, 8'h10);
    rx_fifo_not_empty_i <= 1'b0;
    rchk(ST, 8'h00);
  endtask
  task automatic t_tx;
    for (int i = 0; i < 2; i++) begin
      {tx_empty_i, break_detected_i} <= {2{i == 0}};
      {tx_full_i, tx_underrun_i} <= {2{i == 1}};
      pulse(i == 0 ? PAR : OVR);
      rchk(ST, 8'h0b);
      rchk(ST, 8'h0b);
      pulse(TXRD);
      rchk(ST, 8'h01);
      pulse(RXRD);
      rchk(ST, 8'h00);
      {tx_empty_i, tx_full_i, break_detected_i, tx_underrun_i} <= 4'h0;
      @(posedge clock_i);
    end
  endtask
  task automatic t_modes;
    wr(MD, 8'h08);
    break_at_end_i <= 1'b1;
    pulse(SENT);
    rchk(ST, 8'h00);
    break_at_end_i <= 1'b0;
    pulse(CHK);
    rchk(ST, 8'h00);
    wr(MD, 8'h04);
    pulse(CHK);
    rchk(ST, 8'h04);
    for (int m = 1; m < 4; m += 2) begin
      wr(MD, m[7:0]);
      wr(LM, 8'h03);
      repeat (2) pulse(STEP);
      rchk(ST, 8'h00);
      pulse(STEP);
      rchk(LM, 8'h03);
      rchk(ST, 8'h80);
    end
  endtask
  task automatic t_bypass;
    wr(MD, 8'h00);
    wr(SL, 8'h06);
    wr(EN, 8'h10);
    card_io_i <= 1'b1;
    @(posedge clock_i);
    card_io_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    check({7'h00, irq_o}, 8'h01);
    wr(EN, 8'h00);
    rchk(ST, 8'h10);
    card_io_i <= 1'b1;
    rchk(ST, 8'h00);
  endtask
  task automatic t_irq;
    wr(SL, 8'h08);
    card_detect_ext_i <= 1'b1;
    rchk(ST, 8'h00);
    card_detect_int_i <= 1'b1;
    rchk(ST, 8'h40);
    wr(EN, 8'h40);
    wr(MD, 8'h10);
    logic_clk_en_i <= 1'b0;
    pulse(FLT);
    @(posedge clock_i);
    check({7'h00, irq_o}, 8'h01);
    rchk(ST, 8'h40);
    wr(MD, 8'h00);
    logic_clk_en_i <= 1'b1;
    wr(EN, 8'h00);
    pulse(SUP);
    @(posedge clock_i);
    check({7'h00, irq_o}, 8'h00);
    wr(EN, 8'h20);
    @(posedge clock_i);
    check({7'h00, irq_o}, 8'h01);
    rchk(ST, 8'h20);
    check({7'h00, irq_o}, 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset;
    t_events;
    t_tx;
    t_modes;
    t_bypass;
    t_irq;
    stop_test;
  end
endmodule // tb_card_irq_flags
`default_nettype wire
